/* File: core/pmc_io_latch.v */
// io latch: holds pad values while the latch enable is high
// assumes latch enable comes from the sequencer flop
`timescale 1ns/10ps
`include "pmc_map.vh"

module pmc_io_latch (
    input  wire                   clock,
    input  wire                   rstn,
    input  wire                   clk_en,
    input  wire                   latch_en,
    input  wire [`PMC_IO_W-1:0]   io_in,
    output reg  [`PMC_IO_W-1:0]   io_out_r
);

    // follows io_in a cycle late while released, frozen while latched
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            io_out_r <= {`PMC_IO_W{1'b0}};
        end else if (clk_en && !latch_en) begin
            io_out_r <= io_in;
        end
    end

endmodule

/* File: core/pmc_map.vh */
// constants for the power mode controller: state codes, request codes, cause codes
// assumes inclusion by every design file of the block
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// power states
`define PMC_ST_ACTIVE    3'h0
`define PMC_ST_IDLE      3'h1
`define PMC_ST_STBY_PREP 3'h2
`define PMC_ST_STANDBY   3'h3
`define PMC_ST_SHDN_PREP 3'h4
`define PMC_ST_SHUTDOWN  3'h5
`define PMC_ST_HELD      3'h6
`define PMC_ST_WIDTH     3

// software mode requests
`define PMC_REQ_IDLE     2'h1
`define PMC_REQ_STANDBY  2'h2
`define PMC_REQ_SHUTDOWN 2'h3

// reset cause codes
`define PMC_CAUSE_POR    2'h0
`define PMC_CAUSE_PIN    2'h1
`define PMC_CAUSE_WAKE   2'h2

// io count and watchdog width
`define PMC_IO_W         30
`define PMC_WD_W         16
`define PMC_WD_ONE       16'h0001

`endif

/* File: core/pmc_pin_wake.v */
// pin wake detector: flags a change on any pin marked as shutdown wake source
// assumes pins synchronous to clock
`timescale 1ns/10ps
`include "pmc_map.vh"

module pmc_pin_wake (
    input  wire                   clock,
    input  wire                   rstn,
    input  wire                   clk_en,
    input  wire                   arm,
    input  wire [`PMC_IO_W-1:0]   pins,
    input  wire [`PMC_IO_W-1:0]   wake_sel,
    output reg                    wake_r
);

    reg [`PMC_IO_W-1:0] ref_r;

    // reference sampled while unarmed; high while any selected pin differs from it
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ref_r  <= {`PMC_IO_W{1'b0}};
            wake_r <= 1'b0;
        end else if (clk_en) begin
            if (!arm) begin
                ref_r  <= pins;
                wake_r <= 1'b0;
            end else begin
                wake_r <= |((pins ^ ref_r) & wake_sel);
            end
        end
    end

endmodule

/* File: core/pmc_top.v */
// power mode controller: sequences active, idle, standby, shutdown and held states
// assumes software requests arrive as one-cycle pulses synchronous to clock
//
// Overview of operation
// - idle gates the cpu clock; enabled peripherals keep their clocks
// - any interrupt in idle returns the device to active
// - standby powers only always-on and sensor domains; wakes on pin, timer or sensor event
// - standby wake resumes cpu where it stopped; retained peripherals keep settings
// - all general-purpose pins stay latched throughout standby
// - shutdown removes power from everything including always-on and sensor domains
// - shutdown latches each pin at its pre-entry value until wake
// - change on a shutdown wake pin wakes device as a reset trigger
// - reset cause register tells pin wake, reset pin and power-on apart
// - only latched pins and flash contents survive shutdown
// - high-speed clock runs in active and idle, off otherwise
// - medium-speed clock runs active and idle, optional in standby, else off
// - low-speed clock runs in active, idle and standby, off otherwise
// - full retention active, idle and standby, none shutdown or held
// - reset pin wakes the device from every state
`timescale 1ns/10ps
`include "pmc_map.vh"

module pmc_top (
    input  wire                   clock,
    input  wire                   rstn,
    input  wire                   clk_en,
    input  wire                   reset_pin_n,
    input  wire                   mode_req_valid,
    input  wire [1:0]             mode_req,
    input  wire                   hold_req,
    input  wire                   irq_event,
    input  wire                   rtc_event,
    input  wire                   sensor_event,
    input  wire                   ext_wake_event,
    input  wire                   hf_use_crystal,
    input  wire                   lf_use_crystal,
    input  wire                   mf_in_standby,
    input  wire                   wdt_enable,
    input  wire [`PMC_IO_W-1:0]   io_in,
    input  wire [`PMC_IO_W-1:0]   shdn_wake_sel,
    output reg  [`PMC_ST_WIDTH-1:0] state_r,
    output reg                    cpu_clk_en_r,
    output reg                    periph_clk_en_r,
    output reg                    high_speed_crystal_osc_en_r,
    output reg                    high_speed_rc_osc_en_r,
    output reg                    medium_speed_rc_osc_en_r,
    output reg                    low_speed_crystal_osc_en_r,
    output reg                    low_speed_rc_osc_en_r,
    output reg                    main_pwr_en_r,
    output reg                    always_on_domain_pwr_r,
    output reg                    sensor_pwr_en_r,
    output reg                    reg_retain_r,
    output reg                    sram_retain_r,
    output reg                    cpu_resume_r,
    output reg                    io_latch_r,
    output reg                    sys_reset_r,
    output reg  [1:0]             reset_cause_r,
    output reg  [`PMC_WD_W-1:0]   watchdog_counter_r,
    output wire [`PMC_IO_W-1:0]   io_out
);

    reg [`PMC_ST_WIDTH-1:0] state_nxt;
    reg                     stby_wake_pending_r;
    wire                    shdn_wake;

    // true in states where the high-speed domain is clocked
    function is_run;
        input [`PMC_ST_WIDTH-1:0] s;
        begin
            is_run = (s == `PMC_ST_ACTIVE) || (s == `PMC_ST_IDLE);
        end
    endfunction

    // true in states where pins must be frozen
    function is_latched;
        input [`PMC_ST_WIDTH-1:0] s;
        begin
            is_latched = (s == `PMC_ST_STBY_PREP) || (s == `PMC_ST_STANDBY) ||
                         (s == `PMC_ST_SHDN_PREP) || (s == `PMC_ST_SHUTDOWN);
        end
    endfunction

    // true in states where the low-speed clock and retention stay up
    function is_kept;
        input [`PMC_ST_WIDTH-1:0] s;
        begin
            is_kept = is_run(s) || (s == `PMC_ST_STBY_PREP) || (s == `PMC_ST_STANDBY);
        end
    endfunction

    // true in states where the always-on and sensor domains are powered
    function is_powered;
        input [`PMC_ST_WIDTH-1:0] s;
        begin
            is_powered = (s != `PMC_ST_SHUTDOWN) && (s != `PMC_ST_HELD);
        end
    endfunction

    // true in the single cycle that prepares a low-power entry
    function is_prep;
        input [`PMC_ST_WIDTH-1:0] s;
        begin
            is_prep = (s == `PMC_ST_STBY_PREP) || (s == `PMC_ST_SHDN_PREP);
        end
    endfunction

    // pad hold stage
    pmc_io_latch u_latch (
        .clock    (clock),
        .rstn     (rstn),
        .clk_en   (clk_en),
        .latch_en (io_latch_r),
        .io_in    (io_in),
        .io_out_r (io_out)
    );

    // shutdown pin wake detector
    pmc_pin_wake u_wake (
        .clock    (clock),
        .rstn     (rstn),
        .clk_en   (clk_en),
        .arm      (state_r == `PMC_ST_SHUTDOWN),
        .pins     (io_in),
        .wake_sel (shdn_wake_sel),
        .wake_r   (shdn_wake)
    );

    // next power state
    // standby and shutdown are entered only through a prep cycle, so clocks are
    // gated and pins frozen while the domains still have power; the reset pin
    // overrides every state, held included, since nothing else leaves held
    always @* begin
        state_nxt = state_r;
        case (state_r)
            `PMC_ST_ACTIVE: begin
                if (hold_req) begin
                    state_nxt = `PMC_ST_HELD;
                end else if (mode_req_valid) begin
                    case (mode_req)
                        `PMC_REQ_IDLE:     state_nxt = `PMC_ST_IDLE;
                        `PMC_REQ_STANDBY:  state_nxt = `PMC_ST_STBY_PREP;
                        `PMC_REQ_SHUTDOWN: state_nxt = `PMC_ST_SHDN_PREP;
                        default:           state_nxt = `PMC_ST_ACTIVE;
                    endcase
                end
            end
            `PMC_ST_IDLE: begin
                if (irq_event) begin
                    state_nxt = `PMC_ST_ACTIVE;
                end
            end
            `PMC_ST_STBY_PREP: begin
                state_nxt = `PMC_ST_STANDBY;
            end
            `PMC_ST_STANDBY: begin
                if (stby_wake_pending_r) begin
                    state_nxt = `PMC_ST_ACTIVE;
                end
            end
            `PMC_ST_SHDN_PREP: begin
                state_nxt = `PMC_ST_SHUTDOWN;
            end
            `PMC_ST_SHUTDOWN: begin
                if (shdn_wake) begin
                    state_nxt = `PMC_ST_ACTIVE;
                end
            end
            `PMC_ST_HELD: begin
                state_nxt = `PMC_ST_HELD;
            end
            default: begin
                state_nxt = `PMC_ST_ACTIVE;
            end
        endcase
        if (!reset_pin_n) begin
            state_nxt = `PMC_ST_ACTIVE;
        end
    end

    // standby wake capture; an event in the entry cycle is kept
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stby_wake_pending_r <= 1'b0;
        end else if (clk_en) begin
            if (state_r == `PMC_ST_STBY_PREP || state_r == `PMC_ST_STANDBY) begin
                stby_wake_pending_r <= stby_wake_pending_r | rtc_event | sensor_event
                                       | ext_wake_event;
            end else begin
                stby_wake_pending_r <= 1'b0;
            end
        end
    end

    // state register
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= `PMC_ST_ACTIVE;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // reset cause and system reset pulse; the latest of pin or wake is kept,
    // power-on is only ever recorded by the async reset
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reset_cause_r <= `PMC_CAUSE_POR;
            sys_reset_r   <= 1'b1;
        end else if (clk_en) begin
            if (!reset_pin_n) begin
                reset_cause_r <= `PMC_CAUSE_PIN;
                sys_reset_r   <= 1'b1;
            end else if (state_r == `PMC_ST_SHUTDOWN && shdn_wake) begin
                reset_cause_r <= `PMC_CAUSE_WAKE;
                sys_reset_r   <= 1'b1;
            end else begin
                sys_reset_r   <= 1'b0;
            end
        end
    end

    // clock gating and oscillator enables, following the next state
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cpu_clk_en_r                <= 1'b1;
            periph_clk_en_r             <= 1'b1;
            high_speed_crystal_osc_en_r <= 1'b0;
            high_speed_rc_osc_en_r      <= 1'b1;
            medium_speed_rc_osc_en_r    <= 1'b1;
            low_speed_crystal_osc_en_r  <= 1'b0;
            low_speed_rc_osc_en_r       <= 1'b1;
        end else if (clk_en) begin
            cpu_clk_en_r    <= (state_nxt == `PMC_ST_ACTIVE);
            periph_clk_en_r <= is_run(state_nxt);
            high_speed_crystal_osc_en_r <= is_run(state_nxt) && hf_use_crystal;
            high_speed_rc_osc_en_r      <= is_run(state_nxt) && !hf_use_crystal;
            medium_speed_rc_osc_en_r    <= is_run(state_nxt) ||
                (state_nxt == `PMC_ST_STANDBY && mf_in_standby);
            low_speed_crystal_osc_en_r  <= is_kept(state_nxt) && lf_use_crystal;
            low_speed_rc_osc_en_r       <= is_kept(state_nxt) && !lf_use_crystal;
        end
    end

    // domain power; for standby and shutdown falls only after the prep cycle has gated clocks and latched pins, held drops it at once
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            main_pwr_en_r          <= 1'b1;
            always_on_domain_pwr_r <= 1'b1;
            sensor_pwr_en_r        <= 1'b1;
        end else if (clk_en) begin
            main_pwr_en_r          <= is_run(state_nxt) || is_prep(state_nxt);
            always_on_domain_pwr_r <= is_powered(state_nxt);
            sensor_pwr_en_r        <= is_powered(state_nxt);
        end
    end

    // retention, resume pulse and pin latch
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_retain_r  <= 1'b1;
            sram_retain_r <= 1'b1;
            cpu_resume_r  <= 1'b0;
            io_latch_r    <= 1'b0;
        end else if (clk_en) begin
            reg_retain_r  <= is_kept(state_nxt);
            sram_retain_r <= is_kept(state_nxt);
            cpu_resume_r  <= (state_r == `PMC_ST_STANDBY) &&
                (state_nxt == `PMC_ST_ACTIVE) && reset_pin_n;
            io_latch_r    <= is_latched(state_nxt);
        end
    end

    // watchdog: counts when running, holds in standby, clears when off
    // the standby prep cycle holds too, so no count is lost on the way down
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            watchdog_counter_r <= {`PMC_WD_W{1'b0}};
        end else if (clk_en) begin
            if (!is_run(state_r) && !is_latched(state_r) ||
                state_r == `PMC_ST_SHUTDOWN || state_r == `PMC_ST_SHDN_PREP) begin
                watchdog_counter_r <= {`PMC_WD_W{1'b0}};
            end else if (is_run(state_r) && wdt_enable) begin
                watchdog_counter_r <= watchdog_counter_r + `PMC_WD_ONE;
            end
        end
    end

endmodule

/* File: sim/pmc_checker.sv */
// checker: timing relations between mode state, clocks, power and pins
// assumes bind onto pmc_top, one clock domain, rstn async active low
`timescale 1ns/10ps
`include "pmc_map.vh"

module pmc_checker (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        clk_en,
    input wire logic        reset_pin_n,
    input wire logic        mode_req_valid,
    input wire logic        hold_req,
    input wire logic        irq_event,
    input wire logic        rtc_event,
    input wire logic [29:0] io_in,
    input wire logic [29:0] shdn_wake_sel,
    input wire logic [2:0]  state_r,
    input wire logic        cpu_clk_en_r,
    input wire logic        high_speed_crystal_osc_en_r,
    input wire logic        high_speed_rc_osc_en_r,
    input wire logic        medium_speed_rc_osc_en_r,
    input wire logic        low_speed_crystal_osc_en_r,
    input wire logic        low_speed_rc_osc_en_r,
    input wire logic        main_pwr_en_r,
    input wire logic        always_on_domain_pwr_r,
    input wire logic        sensor_pwr_en_r,
    input wire logic        sram_retain_r,
    input wire logic        cpu_resume_r,
    input wire logic        io_latch_r,
    input wire logic [1:0]  reset_cause_r,
    input wire logic [15:0] watchdog_counter_r,
    input wire logic [29:0] io_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // wake steps: event seen in standby, then resume pulse in active
    sequence s_stby_evt;
        state_r == `PMC_ST_STANDBY && rtc_event && clk_en && reset_pin_n;
    endsequence
    sequence s_resumed;
        ##[1:2] (state_r == `PMC_ST_ACTIVE && cpu_resume_r);
    endsequence
    sequence s_pin_flip;
        state_r == `PMC_ST_SHUTDOWN && clk_en && reset_pin_n
            && |((io_in ^ $past(io_in)) & shdn_wake_sel);
    endsequence
    property p_idle_gate;
        state_r == `PMC_ST_IDLE |-> !cpu_clk_en_r;
    endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("cpu clock on in idle");
    property p_idle_wake;
        state_r == `PMC_ST_IDLE && irq_event && clk_en && reset_pin_n |=> state_r == 3'h0;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("irq did not end idle");
    property p_stby_wake;
        s_stby_evt |-> s_resumed;
    endproperty
    a_stby_wake: assert property (p_stby_wake) else $error("standby wake failed");
    property p_latched;
        state_r inside {`PMC_ST_STANDBY, `PMC_ST_SHUTDOWN} |-> io_latch_r && $stable(io_out);
    endproperty
    a_latched: assert property (p_latched) else $error("pins moved while latched");
    property p_shdn_pwr;
        state_r == `PMC_ST_SHUTDOWN |->
            !(main_pwr_en_r || always_on_domain_pwr_r || sensor_pwr_en_r || sram_retain_r);
    endproperty
    a_shdn_pwr: assert property (p_shdn_pwr) else $error("power left on in shutdown");
    property p_pin_wake;
        s_pin_flip |-> ##[1:3] (state_r == 3'h0 && reset_cause_r == `PMC_CAUSE_WAKE);
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("pin wake missed");
    property p_reset_pin;
        !reset_pin_n && clk_en |=> state_r == 3'h0 && reset_cause_r == `PMC_CAUSE_PIN;
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");
    property p_clocks;
        ((high_speed_crystal_osc_en_r || high_speed_rc_osc_en_r) == (state_r <= 3'h1))
            && (state_r < `PMC_ST_SHUTDOWN || !(medium_speed_rc_osc_en_r
            || low_speed_crystal_osc_en_r || low_speed_rc_osc_en_r));
    endproperty
    a_clocks: assert property (p_clocks) else $error("clock enable wrong for state");
    property p_req_only;
        state_r == 3'h0 && !hold_req && !mode_req_valid |=> state_r == 3'h0;
    endproperty
    a_req_only: assert property (p_req_only) else $error("left active unasked");
    property p_wdt_pause;
        state_r == `PMC_ST_STANDBY && $past(state_r) == 3'h3 |-> $stable(watchdog_counter_r);
    endproperty
    a_wdt_pause: assert property (p_wdt_pause) else $error("watchdog ran in standby");
endmodule

bind pmc_top pmc_checker u_pmc_checker (.*);

/* File: sim/pmc_cpu_model.sv */
// system cpu stand-in: turns a bench command into a one-cycle mode request
// assumes go and code change at the rising clock edge
`timescale 1ns/10ps

module pmc_cpu_model (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       go,
    input  wire logic [1:0] code,
    output logic            mode_req_valid,
    output logic [1:0]      mode_req
);
    // request lasts one cycle; the code field churns while not valid
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode_req_valid <= 1'h0;
            mode_req       <= 2'h0;
        end else begin
            mode_req_valid <= go;
            mode_req       <= go ? code : ~mode_req;
        end
    end
endmodule

/* File: sim/power_mode_controller_tb.sv */
// bench: walks the controller through idle, standby, shutdown and held
// assumes pmc_top, pmc_cpu_model and the bound checker
`timescale 1ns/10ps
`include "pmc_map.vh"

module power_mode_controller_tb;
    reg clock, rstn, clk_en, reset_pin_n, hold_req, irq_event, rtc_event, sensor_event;
    reg ext_wake_event, hf_use_crystal, lf_use_crystal, mf_in_standby, wdt_enable, go;
    reg [1:0] code;
    reg [29:0] io_in, shdn_wake_sel, p;
    wire mode_req_valid, cpu_clk_en_r, periph_clk_en_r, high_speed_crystal_osc_en_r;
    wire high_speed_rc_osc_en_r, medium_speed_rc_osc_en_r, low_speed_crystal_osc_en_r;
    wire low_speed_rc_osc_en_r, main_pwr_en_r, always_on_domain_pwr_r, sensor_pwr_en_r;
    wire reg_retain_r, sram_retain_r, cpu_resume_r, io_latch_r, sys_reset_r;
    wire [1:0] mode_req, reset_cause_r;
    wire [2:0] state_r;
    wire [15:0] watchdog_counter_r;
    wire [29:0] io_out;
    reg [15:0] w;
    integer n_errors, n_checks, i, seen;

    pmc_top u_pmc_top (.*);
    pmc_cpu_model u_pmc_cpu_model (.*);

    // clock at 100 ns period
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    task chk(input string what, input logic [31:0] seen_v, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen_v !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0s expected %h seen %h", what, exp, seen_v);
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task req(input [1:0] c);
        @(posedge clock);
        go   <= 1'h1;
        code <= c;
        @(posedge clock);
        go   <= 1'h0;
    endtask
    task wait_st(input [2:0] s);
        integer k;
        k = 0;
        #1;
        while (state_r !== s && k < 20) begin
            @(posedge clock);
            #1;
            k = k + 1;
        end
        chk("state", state_r, s);
    endtask
    // idle: zero code refused, cpu clock gated with peripheral clock on, watchdog runs, irq returns
    task t_idle;
        chk("cause", reset_cause_r, `PMC_CAUSE_POR);
        chk("retain", reg_retain_r & sram_retain_r, 1);
        req(2'h0);
        cyc(3);
        chk("state", state_r, `PMC_ST_ACTIVE);
        req(`PMC_REQ_IDLE);
        wait_st(`PMC_ST_IDLE);
        chk("cpu clk", {cpu_clk_en_r, periph_clk_en_r}, 1);
        w = watchdog_counter_r;
        cyc(3);
        chk("wdt run", watchdog_counter_r !== w, 1);
        @(posedge clock);
        irq_event <= 1'h1;
        @(posedge clock);
        irq_event <= 1'h0;
        wait_st(`PMC_ST_ACTIVE);
    endtask
    // standby: each wake source in turn, irq and pad changes ignored
    task t_standby;
        @(posedge clock);
        {hf_use_crystal, lf_use_crystal, mf_in_standby} <= 3'h7;
        cyc(2);
        chk("hf xtal", high_speed_crystal_osc_en_r, 1);
        for (i = 0; i < 3; i = i + 1) begin
            req(`PMC_REQ_STANDBY);
            wait_st(`PMC_ST_STANDBY);
            chk("pwr", {main_pwr_en_r, always_on_domain_pwr_r}, 1);
            chk("lf xtal", low_speed_crystal_osc_en_r, 1);
            chk("mf stby", medium_speed_rc_osc_en_r, 1);
            w = watchdog_counter_r;
            p = io_out;
            @(posedge clock);
            io_in     <= ~io_in;
            irq_event <= 1'h1;
            cyc(3);
            chk("wdt hold", watchdog_counter_r, w);
            chk("io hold", io_out, p);
            chk("state", state_r, `PMC_ST_STANDBY);
            @(posedge clock);
            irq_event <= 1'h0;
            {ext_wake_event, sensor_event, rtc_event} <= 3'h1 << i;
            @(posedge clock);
            {ext_wake_event, sensor_event, rtc_event} <= 3'h0;
            seen = 0;
            repeat (4) begin
                @(posedge clock);
                #1;
                if (cpu_resume_r === 1'h1)
                    seen = 1;
            end
            chk("resume", seen, 1);
            chk("state", state_r, `PMC_ST_ACTIVE);
        end
    endtask
    // shutdown: pads frozen, power off, only a selected pin wakes
    task t_shutdown;
        @(posedge clock);
        io_in         <= 30'h2a5c_31e7;
        shdn_wake_sel <= 30'h0000_0001;
        req(`PMC_REQ_SHUTDOWN);
        wait_st(`PMC_ST_SHUTDOWN);
        chk("pwr", always_on_domain_pwr_r | sensor_pwr_en_r, 0);
        chk("retain", sram_retain_r | reg_retain_r, 0);
        @(posedge clock);
        io_in <= 30'h2a5c_31c7;
        cyc(4);
        chk("state", state_r, `PMC_ST_SHUTDOWN);
        chk("io out", io_out, 30'h2a5c_31e7);
        @(posedge clock);
        io_in <= 30'h2a5c_31c6;
        wait_st(`PMC_ST_ACTIVE);
        chk("sysrst", sys_reset_r, 1);
        chk("cause", reset_cause_r, `PMC_CAUSE_WAKE);
    endtask
    // held: hf rc, mf and lf oscillators off, requests refused, reset pin releases
    task t_held;
        @(posedge clock);
        hold_req <= 1'h1;
        @(posedge clock);
        hold_req <= 1'h0;
        wait_st(`PMC_ST_HELD);
        chk("clocks", {high_speed_rc_osc_en_r, medium_speed_rc_osc_en_r,
            low_speed_crystal_osc_en_r, low_speed_rc_osc_en_r}, 0);
        req(`PMC_REQ_IDLE);
        cyc(3);
        chk("state", state_r, `PMC_ST_HELD);
        @(posedge clock);
        reset_pin_n <= 1'h0;
        @(posedge clock);
        reset_pin_n <= 1'h1;
        wait_st(`PMC_ST_ACTIVE);
        chk("sysrst", sys_reset_r, 1);
        chk("cause", reset_cause_r, `PMC_CAUSE_PIN);
    endtask
    // main sequence
    initial begin
        n_errors = 0;
        n_checks = 0;
        {rstn, hold_req, irq_event, rtc_event, sensor_event, ext_wake_event, go} = 7'h00;
        {hf_use_crystal, lf_use_crystal, mf_in_standby, code, io_in, shdn_wake_sel} = 0;
        {clk_en, reset_pin_n, wdt_enable} = 3'h7;
        repeat (10) @(posedge clock);
        rstn <= 1'h1;
        cyc(2);
        t_idle;
        t_standby;
        t_shutdown;
        t_held;
        give_verdict;
    end
    // watchdog against a hang
    initial begin
        repeat (3000) @(posedge clock);
        n_errors = n_errors + 1;
        give_verdict;
    end
endmodule
